// ---- rtl/pattern_next_pkg.sv ----
// package: register indices, reset values and bus carrier for the
// pattern next-data buffer block
// assumes a 32-bit apb bus with one aligned word per register index
package pattern_next_pkg;

   localparam int ADDR_W = 18;
   localparam int GROUPS = 4;

   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_HIGH_PAIR = 16'hffa4;
   localparam logic [15:0] IDX_LOW_UPPER = 16'hffa5;
   localparam logic [15:0] IDX_HIGH_LOWER = 16'hffa6;
   localparam logic [15:0] IDX_LOW_LOWER = 16'hffa7;
   localparam logic [15:0] IDX_ENABLE_LOW = 16'hffa8;
   localparam logic [15:0] IDX_TRIG_SEL = 16'hffa9;
   localparam logic [15:0] IDX_PORT_A = 16'hffaa;
   localparam logic [15:0] IDX_PORT_B = 16'hffab;

   // field positions
   localparam int UPPER_LSB = 4;
   localparam int SEL_W = 2;

   // reset and fixed values
   localparam logic [7:0] BUF_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] TRIG_SEL_RESET = 8'hff;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [3:0] RESERVED_NIBBLE = 4'hf;
   localparam logic [7:0] RESERVED_BYTE = 8'hff;
   localparam logic [7:0] UPPER_MASK = 8'hf0;
   localparam logic [7:0] LOWER_MASK = 8'h0f;
   localparam logic [7:0] FULL_MASK = 8'hff;
   localparam logic [7:0] NO_MASK = 8'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic [31:0] wdata;
   } apbReq_t;

endpackage : pattern_next_pkg

// ---- rtl/trigger_select.sv ----
// trigger selector: picks one timer compare-match strobe per group
// assumes strobes are one-cycle pulses synchronous to the block clock
`timescale 1ns/1ps
module trigger_select (
   // selector fields, two bits per group
   input wire logic [7:0] trigSel,
   // timer compare-match strobes, channels 3..0
   input wire logic [3:0] cmpMatch,
   // per-group fire and shared-trigger flags
   output logic [3:0] groupFire,
   output logic sameLow,
   output logic sameHigh
);

   genvar g;
   generate
      for (g = 0; g < pattern_next_pkg::GROUPS; g++)
      begin : gSel
         assign groupFire[g] = cmpMatch[trigSel[g*2 +: pattern_next_pkg::SEL_W]];
      end
   endgenerate

   // groups share a trigger when their selector fields match
   assign sameLow = (trigSel[3:2] == trigSel[1:0]);
   assign sameHigh = (trigSel[7:6] == trigSel[5:4]);

endmodule : trigger_select

// ---- rtl/next_buffer_map.sv ----
// next-data buffer with its two-address nibble layout
// assumes hit and write strobes come from an apb access phase
`timescale 1ns/1ps
module next_buffer_map (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   // layout select
   input wire logic sameTrigger,
   // register access
   input wire logic hitUpper,
   input wire logic hitLower,
   input wire logic wrEn,
   input wire logic [7:0] wdata,
   // buffer contents and read view
   output logic [7:0] buffer,
   output logic [7:0] readData
);

   logic [7:0] buffer_q;
   logic [7:0] buffer_d;
   logic [7:0] upperMask;
   logic [7:0] lowerMask;
   logic [7:0] wrMask;
   logic [7:0] readUpper;
   logic [7:0] readLower;

   // shared trigger: whole byte at the first address, second all reserved
   assign upperMask = sameTrigger ? pattern_next_pkg::FULL_MASK
                                  : pattern_next_pkg::UPPER_MASK;
   assign lowerMask = sameTrigger ? pattern_next_pkg::NO_MASK
                                  : pattern_next_pkg::LOWER_MASK;
   assign wrMask = !wrEn ? pattern_next_pkg::NO_MASK
                 : hitUpper ? upperMask
                 : hitLower ? lowerMask
                 : pattern_next_pkg::NO_MASK;
   assign buffer_d = (buffer_q & ~wrMask) | (wdata & wrMask);

   assign readUpper = sameTrigger ? buffer_q
                    : {buffer_q[7:4], pattern_next_pkg::RESERVED_NIBBLE};
   assign readLower = sameTrigger ? pattern_next_pkg::RESERVED_BYTE
                    : {pattern_next_pkg::RESERVED_NIBBLE, buffer_q[3:0]};
   assign readData = hitUpper ? readUpper : readLower;
   assign buffer = buffer_q;

   // hardware standby clears like reset; software standby is not seen here
   always_ff @(posedge clk)
   begin
      if (!rst_n || clear)
         buffer_q <= pattern_next_pkg::BUF_RESET;
      else
         buffer_q <= buffer_d;
   end

endmodule : next_buffer_map

// ---- rtl/pattern_next_data_buffer.sv ----
// top of the pattern next-data buffer: apb slave, enables, trigger
// selector, buffer-to-latch transfer and port latches
// assumes timer strobes and standby level are synchronous to clk
`timescale 1ns/1ps

// Function
// - split low trigger: nibbles at two addresses
// - split low: unused nibbles read ones, ignore writes
// - high buffer transfers to port B latch
// - high buffer layout follows shared trigger
// - buffers clear on reset and hardware standby
// - shared high trigger: whole byte first address
// - shared high: second address reads all ones
// - split high trigger: nibbles at two addresses
// - split high: unused nibbles read ones
// - bit fourteen internal, still buffered and transferred
// - enabled low bits copy on selected event
// - disabled low bits keep latch value
// - low enable clears on reset and standby
// - each enable bit gates its own output
// - low buffer transfers to port A latch
// - per-group selector picks timer channel, resets ff
// - shared low trigger: whole byte first address
module pattern_next_data_buffer (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pattern_next_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer compare-match strobes, channels 3..0
   input wire logic [3:0] cmpMatch,
   // power state and high-side enables from neighbouring logic
   input wire logic hwStandby,
   input wire logic [7:0] highEnable,
   // port latches and pattern pins
   output logic [7:0] portALatch,
   output logic [7:0] portBLatch,
   output logic [14:0] patternPins
);

   pattern_next_pkg::apbReq_t req;
   logic [15:0] idx;
   logic aligned;
   logic setupPhase;
   logic accessPhase;
   logic wrEn;
   logic hitHighPair;
   logic hitLowUpper;
   logic hitHighLower;
   logic hitLowLower;
   logic hitEnable;
   logic hitTrig;
   logic hitPortA;
   logic hitPortB;
   logic anyHit;
   logic [7:0] readByte;
   logic [7:0] lowRead;
   logic [7:0] highRead;
   logic [7:0] lowBuf;
   logic [7:0] highBuf;
   logic [3:0] groupFire;
   logic sameLow;
   logic sameHigh;
   logic [7:0] fireA;
   logic [7:0] fireB;
   logic [7:0] enableLow_q;
   logic [7:0] enableLow_d;
   logic [7:0] trigSel_q;
   logic [7:0] trigSel_d;
   logic [7:0] portA_q;
   logic [7:0] portA_d;
   logic [7:0] portB_q;
   logic [7:0] portB_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // bus decode
   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign idx = req.addr[pattern_next_pkg::ADDR_W-1:2];
   assign aligned = (req.addr[1:0] == 2'h0);
   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign wrEn = accessPhase && req.write;

   assign hitHighPair = aligned && (idx == pattern_next_pkg::IDX_HIGH_PAIR);
   assign hitLowUpper = aligned && (idx == pattern_next_pkg::IDX_LOW_UPPER);
   assign hitHighLower = aligned && (idx == pattern_next_pkg::IDX_HIGH_LOWER);
   assign hitLowLower = aligned && (idx == pattern_next_pkg::IDX_LOW_LOWER);
   assign hitEnable = aligned && (idx == pattern_next_pkg::IDX_ENABLE_LOW);
   assign hitTrig = aligned && (idx == pattern_next_pkg::IDX_TRIG_SEL);
   assign hitPortA = aligned && (idx == pattern_next_pkg::IDX_PORT_A);
   assign hitPortB = aligned && (idx == pattern_next_pkg::IDX_PORT_B);
   assign anyHit = hitHighPair || hitLowUpper || hitHighLower || hitLowLower
                 || hitEnable || hitTrig || hitPortA || hitPortB;

   // zero-wait slave; read data were captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = accessPhase && !anyHit;
   assign prdata = prdata_q;

   // trigger selection per group
   trigger_select uTrig (
      .trigSel(trigSel_q),
      .cmpMatch(cmpMatch),
      .groupFire(groupFire),
      .sameLow(sameLow),
      .sameHigh(sameHigh)
   );

   // low buffer: groups 1 and 0
   next_buffer_map uLowBuf (
      .clk(clk),
      .rst_n(rst_n),
      .clear(hwStandby),
      .sameTrigger(sameLow),
      .hitUpper(hitLowUpper),
      .hitLower(hitLowLower),
      .wrEn(wrEn),
      .wdata(req.wdata[7:0]),
      .buffer(lowBuf),
      .readData(lowRead)
   );

   // high buffer: groups 3 and 2
   next_buffer_map uHighBuf (
      .clk(clk),
      .rst_n(rst_n),
      .clear(hwStandby),
      .sameTrigger(sameHigh),
      .hitUpper(hitHighPair),
      .hitLower(hitHighLower),
      .wrEn(wrEn),
      .wdata(req.wdata[7:0]),
      .buffer(highBuf),
      .readData(highRead)
   );

   // read selection
   assign readByte = (hitLowUpper || hitLowLower) ? lowRead
                   : (hitHighPair || hitHighLower) ? highRead
                   : hitEnable ? enableLow_q
                   : hitTrig ? trigSel_q
                   : hitPortA ? portA_q
                   : hitPortB ? portB_q
                   : 8'h00;
   assign prdata_d = (setupPhase && !req.write) ? {24'h000000, readByte} : prdata_q;

   // control registers
   assign enableLow_d = (wrEn && hitEnable) ? req.wdata[7:0] : enableLow_q;
   assign trigSel_d = (wrEn && hitTrig) ? req.wdata[7:0] : trigSel_q;

   // per-bit transfer: group of bit i is i/4 within each port
   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : gBit
         assign fireA[i] = groupFire[i / 4] && enableLow_q[i];
         assign fireB[i] = groupFire[2 + i / 4] && highEnable[i];
         assign portA_d[i] = fireA[i] ? lowBuf[i] : portA_q[i];
         assign portB_d[i] = fireB[i] ? highBuf[i] : portB_q[i];
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (!rst_n || hwStandby)
      begin
         enableLow_q <= pattern_next_pkg::ENABLE_RESET;
         trigSel_q <= pattern_next_pkg::TRIG_SEL_RESET;
      end
      else
      begin
         enableLow_q <= enableLow_d;
         trigSel_q <= trigSel_d;
      end
   end

   // latches update on the same edge that samples the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n || hwStandby)
      begin
         portA_q <= pattern_next_pkg::LATCH_RESET;
         portB_q <= pattern_next_pkg::LATCH_RESET;
      end
      else
      begin
         portA_q <= portA_d;
         portB_q <= portB_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prdata_q <= 32'h00000000;
      else
         prdata_q <= prdata_d;
   end

   assign portALatch = portA_q;
   assign portBLatch = portB_q;
   // bit fourteen has no pin; its latch bit still exists
   assign patternPins = {portB_q[7], portB_q[5:0], portA_q};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence sReadSetup(logic hit);
      setupPhase && !req.write && hit;
   endsequence

   sequence sQuietIdle;
      !hwStandby && (enableLow_q == 8'h00) ##1 !hwStandby;
   endsequence

   AST_LOW_SPLIT_READ: assert property (
      sReadSetup(hitLowUpper && !sameLow) |=>
         prdata[3:0] == 4'hf && prdata[7:4] == $past(lowBuf[7:4]))
      else $error("split low upper address read wrong");

   AST_LOW_SAME_RES: assert property (
      sReadSetup(hitLowLower && sameLow) |=> prdata[7:0] == 8'hff)
      else $error("shared low second address not all ones");

   AST_HIGH_SAME_WRITE: assert property (
      wrEn && hitHighPair && sameHigh && !hwStandby |=>
         highBuf == $past(req.wdata[7:0]))
      else $error("shared high write not stored whole");

   AST_HIGH_RES_WRITE: assert property (
      wrEn && hitHighLower && sameHigh && !hwStandby |=> $stable(highBuf))
      else $error("reserved high address changed buffer");

   AST_HIGH_SPLIT_WRITE: assert property (
      wrEn && hitHighPair && !sameHigh && !hwStandby |=>
         highBuf[3:0] == $past(highBuf[3:0]) && highBuf[7:4] == $past(req.wdata[7:4]))
      else $error("split high write touched wrong nibble");

   AST_STANDBY_CLEAR: assert property (
      hwStandby |=> highBuf == 8'h00 && lowBuf == 8'h00 && enableLow_q == 8'h00)
      else $error("standby did not clear buffers");

   AST_TRANSFER_A: assert property (
      groupFire[0] && enableLow_q[0] && !hwStandby |=> portALatch[0] == $past(lowBuf[0]))
      else $error("enabled low bit not transferred");

   AST_GATE_BIT: assert property (
      groupFire[1] && !enableLow_q[4] && !hwStandby |=> $stable(portALatch[4]))
      else $error("disabled enable bit let data through");

   AST_HOLD_A: assert property (
      sQuietIdle |-> $stable(portALatch))
      else $error("latch moved with all enables clear");

   AST_BIT14: assert property (
      groupFire[3] && highEnable[6] && !hwStandby |=> portBLatch[6] == $past(highBuf[6]))
      else $error("internal bit fourteen not transferred");

   AST_TRIG_RESET: assert property (
      $rose(rst_n) |-> trigSel_q == 8'hff && groupFire == {4{cmpMatch[3]}})
      else $error("selector not at channel three after reset");

   AST_LOW_SPLIT_WRITE: assert property (
      wrEn && hitLowLower && !sameLow && !hwStandby |=>
         lowBuf[7:4] == $past(lowBuf[7:4]) && lowBuf[3:0] == $past(req.wdata[3:0]))
      else $error("split low second address write wrong");

   AST_LOW_SAME_WRITE: assert property (
      wrEn && hitLowUpper && sameLow && !hwStandby |=>
         lowBuf == $past(req.wdata[7:0]))
      else $error("shared low write not stored whole");

   AST_HIGH_SPLIT_READ: assert property (
      sReadSetup(hitHighLower && !sameHigh) |=>
         prdata[7:4] == 4'hf && prdata[3:0] == $past(highBuf[3:0]))
      else $error("split high second address read wrong");

   AST_HIGH_SAME_RES: assert property (
      sReadSetup(hitHighLower && sameHigh) |=> prdata[7:0] == 8'hff)
      else $error("shared high second address not all ones");

   AST_TRANSFER_B: assert property (
      groupFire[3] && (highEnable[7:4] == 4'hf) && !hwStandby |=>
         portBLatch[7:4] == $past(highBuf[7:4]))
      else $error("enabled high nibble not transferred");

   AST_GATE_B: assert property (
      groupFire[2] && !highEnable[0] && !hwStandby |=> $stable(portBLatch[0]))
      else $error("disabled high bit let data through");

   AST_SEL_STANDBY: assert property (
      hwStandby |=> trigSel_q == 8'hff)
      else $error("selector not back at channel three after standby");

endmodule : pattern_next_data_buffer

// ---- sim/timer_strobe_model.sv ----
// timer-side model: turns a bench request into one-cycle compare-match strobes
// assumes requests change right after a rising edge of clk
`timescale 1ns/1ps
module timer_strobe_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request from the bench, slow adds one cycle of delay
   input wire logic [3:0] fireReq,
   input wire logic slow,
   // compare-match strobes, channels 3..0
   output logic [3:0] cmpMatch
);
   logic [3:0] pend_q;
   logic [3:0] strobe_q;
   assign cmpMatch = strobe_q;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pend_q <= 4'h0;
         strobe_q <= 4'h0;
      end
      else
      begin
         pend_q <= slow ? fireReq : 4'h0;
         strobe_q <= slow ? pend_q : fireReq;
      end
   end
endmodule : timer_strobe_model

// ---- sim/tb_pattern_next_data_buffer.sv ----
// bench for the pattern next-data buffer: register layouts and timed transfers
// assumes the timer strobe model and a 100 MHz clock
`timescale 1ns/1ps
module tb_pattern_next_data_buffer;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [pattern_next_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] cmpMatch;
   logic [3:0] fireReq = 4'h0;
   logic slow = 1'b0;
   logic hwStandby = 1'b0;
   logic [7:0] highEnable = 8'hff;
   logic [7:0] portALatch;
   logic [7:0] portBLatch;
   logic [14:0] patternPins;
   int mismatches = 0;
   int cmp_count = 0;

   always #5 clk = ~clk;

   pattern_next_data_buffer u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmpMatch(cmpMatch),
      .hwStandby(hwStandby), .highEnable(highEnable), .portALatch(portALatch),
      .portBLatch(portBLatch), .patternPins(patternPins));

   timer_strobe_model u_timer (.clk(clk), .rst_n(rst_n), .fireReq(fireReq),
      .slow(slow), .cmpMatch(cmpMatch));

   task automatic end_sim();
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         mismatches++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, idx, d, rd, err);
   endtask : wr

   task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, idx, 8'h00, rd, err);
      chk(rd, {24'h0, exp});
      chk({31'h0, err}, 32'h0);
   endtask : rdchk

   // strobe one channel; latches checked at falling edges before and after the strobed edge
   task automatic fire(input int ch, input logic sl, input logic [7:0] a0,
      input logic [7:0] a1, input logic [7:0] b0, input logic [7:0] b1);
      int n;
      slow <= sl;
      fireReq <= 4'h1 << ch;
      @(posedge clk);
      fireReq <= 4'h0;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (cmpMatch[ch] !== 1'b1 && n < 8);
      if (cmpMatch[ch] !== 1'b1)
      begin
         mismatches++;
         end_sim();
      end
      chk({24'h0, portALatch}, {24'h0, a0});
      chk({24'h0, portBLatch}, {24'h0, b0});
      @(negedge clk);
      chk({24'h0, portALatch}, {24'h0, a1});
      chk({24'h0, portBLatch}, {24'h0, b1});
      chk({17'h0, patternPins}, {17'h0, b1[7], b1[5:0], a1});
      @(posedge clk);
   endtask : fire

   task automatic layout(input logic [7:0] w[4], input logic [7:0] r[4]);
      for (int i = 0; i < 4; i++)
         wr(pattern_next_pkg::IDX_HIGH_PAIR + 16'(i), w[i]);
      for (int i = 0; i < 4; i++)
         rdchk(pattern_next_pkg::IDX_HIGH_PAIR + 16'(i), r[i]);
   endtask : layout

   task automatic s_reset();
      logic [7:0] exp[6] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff};
      for (int i = 0; i < 6; i++)
         rdchk(pattern_next_pkg::IDX_HIGH_PAIR + 16'(i), exp[i]);
   endtask : s_reset

   task automatic s_shared();
      layout('{8'ha5, 8'h3c, 8'h00, 8'h00}, '{8'ha5, 8'h3c, 8'hff, 8'hff});
   endtask : s_shared

   // each group on its own channel: group g follows channel g
   task automatic s_split();
      wr(pattern_next_pkg::IDX_TRIG_SEL, 8'he4);
      layout('{8'h5a, 8'h9e, 8'hc4, 8'h76}, '{8'h5f, 8'h9f, 8'hf4, 8'hf6});
      rdchk(pattern_next_pkg::IDX_TRIG_SEL, 8'he4);
   endtask : s_split

   task automatic s_transfer();
      wr(pattern_next_pkg::IDX_ENABLE_LOW, 8'h0f);
      highEnable <= 8'hf0;
      fire(0, 1'b0, 8'h00, 8'h06, 8'h00, 8'h00);
      fire(1, 1'b1, 8'h06, 8'h06, 8'h00, 8'h00);
      fire(2, 1'b0, 8'h06, 8'h06, 8'h00, 8'h00);
      fire(3, 1'b1, 8'h06, 8'h06, 8'h00, 8'h50);
      rdchk(pattern_next_pkg::IDX_PORT_A, 8'h06);
      rdchk(pattern_next_pkg::IDX_PORT_B, 8'h50);
   endtask : s_transfer

   task automatic s_standby();
      hwStandby <= 1'b1;
      @(posedge clk);
      hwStandby <= 1'b0;
      @(posedge clk);
      chk({16'h0, portALatch, portBLatch}, 32'h0);
      s_reset();
   endtask : s_standby

   // walk the low enables one at a time on the default channel
   task automatic s_enable_walk();
      logic [7:0] expA;
      expA = 8'h00;
      wr(pattern_next_pkg::IDX_LOW_UPPER, 8'hff);
      for (int n = 0; n < 8; n++)
      begin
         wr(pattern_next_pkg::IDX_ENABLE_LOW, 8'h01 << n);
         fire(3, n[0], expA, expA | (8'h01 << n), 8'h00, 8'h00);
         expA = expA | (8'h01 << n);
      end
   endtask : s_enable_walk

   task automatic s_unmapped();
      logic [31:0] rd;
      logic err;
      apb(1'b0, 16'h0000, 8'h00, rd, err);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
   endtask : s_unmapped

   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      s_reset();
      s_shared();
      s_split();
      s_transfer();
      s_standby();
      s_enable_walk();
      s_unmapped();
      end_sim();
   end
endmodule : tb_pattern_next_data_buffer
